// >>> logic/tlal_map.vh
// Purpose: constants for the 10 Mbps link, negotiation and indicator logic
// Assumes: 40 MHz clk, APB register access, byte addresses
// Notes: times kept in their own unit, cycle counts derived from them
//
// Behaviour
// - Half duplex 10M: collision when transmitting and receiving together.
// - Classify received pulses: normal link pulse, fast pulse burst, idles.
// - In 10M mode send normal link pulses, each 100 ns wide.
// - Detect reversed receive polarity from link pulses; invert data.
// - Jabber enabled in 10M: block transmit after 26.2 to 39 ms.
// - Keep jabber block until transmit enable idle for 314 ms.
// - Full duplex 10M: no collision, squelch test or transmit carrier.
// - Negotiation picks highest common mode: 100F, 100H, 10F, 10H.
// - Exchange abilities by fast pulse bursts, then native link pulses.
// - Reset or renegotiate command restarts negotiation from the start.
// - Negotiate only while enable bit 12 set; else clear it, parallel detect.
// - Advertised ability has bits 0, 1, 2, 3 and 5 set.
// - Reset, link fail or negotiate: first a long quiet, pulse-free period.
// - No data packets sent while negotiating or parallel detecting.
// - Watch fast bursts and native pulses together; use the one seen.
// - Link indicator off until valid link, then on, active low.
// - Activity indicator toggles while wire activity is seen.
// - Speed indicator on for 100M, off 10M; hold last on link fail.
// - Forced speed drives speed indicator regardless of link status.
// - Parallel detect with only normal link pulses settles on 10M.
`ifndef TLAL_MAP_VH
`define TLAL_MAP_VH
`define TLAL_CLK_KHZ 40000
`define TLAL_NLP_NS 100
`define TLAL_NLP_CYC ((`TLAL_NLP_NS*`TLAL_CLK_KHZ+999999)/1000000)
`define TLAL_JAB_US 26200
`define TLAL_JAB_CYC (`TLAL_JAB_US*(`TLAL_CLK_KHZ/1000))
`define TLAL_UNJAB_MS 314
`define TLAL_UNJAB_CYC (`TLAL_UNJAB_MS*`TLAL_CLK_KHZ)
`define TLAL_QUIET_MS 1200
`define TLAL_QUIET_CYC (`TLAL_QUIET_MS*`TLAL_CLK_KHZ)
`define TLAL_NLP_GAP_MS 16
`define TLAL_NLP_GAP_CYC (`TLAL_NLP_GAP_MS*`TLAL_CLK_KHZ)
`define TLAL_BLINK_MS 50
`define TLAL_BLINK_CYC (`TLAL_BLINK_MS*`TLAL_CLK_KHZ)
`define TLAL_ADV_ABILITY 6'h2F
`define TLAL_OFF_CTRL 12'h000
`define TLAL_OFF_STAT 12'h004
`define TLAL_OFF_ADV 12'h008
`define TLAL_OFF_PART 12'h00C
`define TLAL_BIT_ANEN 12
`define TLAL_BIT_RENEG 9
`define TLAL_BIT_JABEN 0
`define TLAL_BIT_FDX 1
`define TLAL_BIT_F100 2
`define TLAL_CTRL_RST 32'h00001001
`define TLAL_MODE_100F 4'h8
`define TLAL_MODE_100H 4'h4
`define TLAL_MODE_10F 4'h2
`define TLAL_MODE_10H 4'h1
`endif

// >>> logic/tlal_link.v
// Purpose: 10 Mbps link control, negotiation sequencing and indicators
// Assumes: pulse classes arrive already qualified from the analog receiver
// Notes: long timers are parameters so simulation can shorten them
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "tlal_map.vh"
module tlal_link #(
   parameter [31:0] JAB_CYC = `TLAL_JAB_CYC,
   parameter [31:0] UNJAB_CYC = `TLAL_UNJAB_CYC,
   parameter [31:0] QUIET_CYC = `TLAL_QUIET_CYC,
   parameter [31:0] NLP_GAP_CYC = `TLAL_NLP_GAP_CYC,
   parameter [31:0] BLINK_CYC = `TLAL_BLINK_CYC
) (
   input wire clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire mac_tx_en,
   input wire rx_active,
   input wire rx_data,
   input wire rx_nlp,
   input wire rx_nlp_neg,
   input wire rx_flp,
   input wire rx_idle100,
   input wire flp_done,
   input wire [5:0] partner_ability,
   output reg tx_gate,
   output reg tx_link_pulse,
   output reg flp_send,
   output reg collision,
   output reg carrier_sense,
   output reg rx_data_fixed,
   output reg speed_100,
   output reg full_duplex,
   output reg link_led_n,
   output reg act_led_n,
   output reg speed_led_n
);
   localparam ST_QUIET = 4'h1;
   localparam ST_DETECT = 4'h2;
   localparam ST_UP = 4'h4;
   localparam ST_FORCED = 4'h8;

   reg [3:0] st_reg;
   reg [31:0] ctrl_reg;
   reg [31:0] tmr_reg;
   reg [31:0] jab_reg;
   reg jabbed_reg;
   reg pol_inv_reg;
   reg [31:0] gap_reg;
   reg [31:0] blink_reg;
   reg [31:0] nlp_w_reg;
   reg [3:0] mode_reg;
   reg an_ok_reg;
   wire wr;
   wire reneg;
   wire an_en;
   wire link_up;
   wire [5:0] common;
   wire half10;
   wire hit_ctrl;
   wire hit_stat;
   wire hit_adv;
   wire hit_part;
   wire nlp_only;
   wire pd_hit;
   wire pulse_hold;
   wire fdx10;
   wire [31:0] stat_word;
   reg [31:0] ctrl_next;
   reg [3:0] res_mode;
   reg res_100;
   reg res_fdx;
   reg [31:0] jab_next;
   reg jabbed_next;

   assign wr = psel & penable & pwrite;
   assign reneg = wr && paddr == `TLAL_OFF_CTRL &&
      pwdata[`TLAL_BIT_RENEG];
   assign an_en = ctrl_reg[`TLAL_BIT_ANEN];
   assign link_up = st_reg == ST_UP || st_reg == ST_FORCED;
   assign common = `TLAL_ADV_ABILITY & partner_ability;
   assign half10 = ~speed_100 & ~full_duplex;
   assign fdx10 = full_duplex & ~speed_100;
   assign hit_ctrl = paddr == `TLAL_OFF_CTRL;
   assign hit_stat = paddr == `TLAL_OFF_STAT;
   assign hit_adv = paddr == `TLAL_OFF_ADV;
   assign hit_part = paddr == `TLAL_OFF_PART;
   assign nlp_only = rx_nlp && !rx_flp;
   assign pd_hit = st_reg == ST_DETECT && an_en && nlp_only &&
      tmr_reg >= NLP_GAP_CYC;
   // A started pulse always runs its full width
   assign pulse_hold = (st_reg == ST_QUIET || speed_100 || mac_tx_en) &&
      !tx_link_pulse;
   // Status word: state, mode, link, jabber, polarity, done
   assign stat_word = {20'h00000, an_ok_reg, pol_inv_reg, jabbed_reg,
      link_up, mode_reg, st_reg};

   // Control word next value; software write beats hardware clear
   always @* begin
      ctrl_next = ctrl_reg;
      if (wr && hit_ctrl) begin
         ctrl_next = pwdata;
         ctrl_next[`TLAL_BIT_RENEG] = 1'b0;
      end else if (pd_hit) begin
         ctrl_next[`TLAL_BIT_ANEN] = 1'b0;
      end
   end

   // Highest common mode wins
   always @* begin
      res_mode = `TLAL_MODE_10H;
      res_100 = 1'b0;
      res_fdx = 1'b0;
      if (common[3]) begin
         res_mode = `TLAL_MODE_100F;
         res_100 = 1'b1;
         res_fdx = 1'b1;
      end else if (common[2]) begin
         res_mode = `TLAL_MODE_100H;
         res_100 = 1'b1;
      end else if (common[1]) begin
         res_mode = `TLAL_MODE_10F;
         res_fdx = 1'b1;
      end
   end

   // Jabber timer next state
   always @* begin
      jab_next = jab_reg;
      jabbed_next = jabbed_reg;
      if (jabbed_reg) begin
         if (mac_tx_en) begin
            jab_next = 32'h00000000;
         end else if (jab_reg >= UNJAB_CYC) begin
            jabbed_next = 1'b0;
            jab_next = 32'h00000000;
         end else begin
            jab_next = jab_reg + 32'h00000001;
         end
      end else if (!mac_tx_en) begin
         jab_next = 32'h00000000;
      end else if (ctrl_reg[`TLAL_BIT_JABEN] && !speed_100) begin
         if (jab_reg >= JAB_CYC) begin
            jabbed_next = 1'b1;
            jab_next = 32'h00000000;
         end else begin
            jab_next = jab_reg + 32'h00000001;
         end
      end
   end

   // APB slave, zero wait states
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         ctrl_reg <= `TLAL_CTRL_RST;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel & ~penable) begin
            pslverr <= ~(hit_ctrl | hit_stat | hit_adv | hit_part);
            case (paddr)
               `TLAL_OFF_CTRL: prdata <= ctrl_reg;
               `TLAL_OFF_STAT: prdata <= stat_word;
               `TLAL_OFF_ADV: prdata <= {26'h0000000,
                  `TLAL_ADV_ABILITY};
               `TLAL_OFF_PART: prdata <= {26'h0000000, partner_ability};
               default: prdata <= 32'h00000000;
            endcase
         end
         ctrl_reg <= ctrl_next;
      end
   end

   // Negotiation sequencer
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= ST_QUIET;
         tmr_reg <= 32'h00000000;
         mode_reg <= 4'h0;
         an_ok_reg <= 1'b0;
         speed_100 <= 1'b0;
         full_duplex <= 1'b0;
         flp_send <= 1'b0;
         nlp_w_reg <= 32'h00000000;
      end else begin
         tmr_reg <= tmr_reg + 32'h00000001;
         flp_send <= 1'b0;
         if (reneg) begin
            st_reg <= ST_QUIET;
            tmr_reg <= 32'h00000000;
            an_ok_reg <= 1'b0;
         end else begin
            case (st_reg)
               ST_QUIET: begin
                  if (tmr_reg >= QUIET_CYC) begin
                     tmr_reg <= 32'h00000000;
                     nlp_w_reg <= 32'h00000000;
                     if (!an_en) begin
                        st_reg <= ST_FORCED;
                        speed_100 <= ctrl_reg[`TLAL_BIT_F100];
                        full_duplex <= ctrl_reg[`TLAL_BIT_FDX];
                     end else begin
                        st_reg <= ST_DETECT;
                     end
                  end
               end
               ST_DETECT: begin
                  flp_send <= an_en;
                  if (rx_nlp)
                     nlp_w_reg <= nlp_w_reg + 32'h00000001;
                  if (an_en && flp_done) begin
                     st_reg <= ST_UP;
                     an_ok_reg <= 1'b1;
                     mode_reg <= res_mode;
                     speed_100 <= res_100;
                     full_duplex <= res_fdx;
                  end else if (rx_idle100) begin
                     st_reg <= ST_UP;
                     mode_reg <= `TLAL_MODE_100H;
                     speed_100 <= 1'b1;
                     full_duplex <= 1'b0;
                  end else if (nlp_only &&
                        (!an_en || tmr_reg >= NLP_GAP_CYC)) begin
                     st_reg <= ST_UP;
                     mode_reg <= `TLAL_MODE_10H;
                     speed_100 <= 1'b0;
                     full_duplex <= 1'b0;
                  end
               end
               ST_UP: begin
                  if (rx_nlp | rx_idle100 | rx_active)
                     tmr_reg <= 32'h00000000;
                  else if (tmr_reg >= NLP_GAP_CYC * 32'h00000003) begin
                     st_reg <= ST_QUIET;
                     tmr_reg <= 32'h00000000;
                     an_ok_reg <= 1'b0;
                  end
               end
               ST_FORCED: begin
                  speed_100 <= ctrl_reg[`TLAL_BIT_F100];
                  full_duplex <= ctrl_reg[`TLAL_BIT_FDX];
                  if (an_en) begin
                     st_reg <= ST_QUIET;
                     tmr_reg <= 32'h00000000;
                  end
               end
               default: st_reg <= ST_QUIET;
            endcase
         end
      end
   end

   // Jabber, link pulses, data path
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         jab_reg <= 32'h00000000;
         jabbed_reg <= 1'b0;
         gap_reg <= 32'h00000000;
         tx_link_pulse <= 1'b0;
         tx_gate <= 1'b0;
         collision <= 1'b0;
         carrier_sense <= 1'b0;
         pol_inv_reg <= 1'b0;
         rx_data_fixed <= 1'b0;
      end else begin
         jab_reg <= jab_next;
         jabbed_reg <= jabbed_next;
         tx_gate <= mac_tx_en & ~jabbed_reg & link_up;
         gap_reg <= gap_reg + 32'h00000001;
         if (pulse_hold) begin
            gap_reg <= 32'h00000000;
            tx_link_pulse <= 1'b0;
         end else if (gap_reg >= NLP_GAP_CYC) begin
            gap_reg <= 32'h00000000;
            tx_link_pulse <= 1'b1;
         end else if (gap_reg >= `TLAL_NLP_CYC - 1) begin
            tx_link_pulse <= 1'b0;
         end
         if (rx_nlp)
            pol_inv_reg <= 1'b0;
         else if (rx_nlp_neg)
            pol_inv_reg <= 1'b1;
         rx_data_fixed <= rx_data ^ pol_inv_reg;
         collision <= half10 & mac_tx_en & rx_active;
         carrier_sense <= rx_active |
            (mac_tx_en & ~fdx10);
      end
   end

   // Indicators
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link_led_n <= 1'b1;
         act_led_n <= 1'b1;
         speed_led_n <= 1'b1;
         blink_reg <= 32'h00000000;
      end else begin
         link_led_n <= ~link_up;
         if (st_reg == ST_FORCED || !an_en)
            speed_led_n <= ~ctrl_reg[`TLAL_BIT_F100];
         else if (st_reg == ST_UP)
            speed_led_n <= ~speed_100;
         if (rx_active | tx_gate) begin
            blink_reg <= blink_reg + 32'h00000001;
            if (blink_reg >= BLINK_CYC) begin
               blink_reg <= 32'h00000000;
               act_led_n <= ~act_led_n;
            end
         end else begin
            blink_reg <= 32'h00000000;
            act_led_n <= 1'b1;
         end
      end
   end
   // classes come in as rx_nlp, rx_flp, rx_idle100
endmodule // tlal_link

// >>> verification/tlal_link_monitor.sv
// Purpose: port checker for the link control block
// Assumes: one clock, rst_n asynchronous active low
// Notes: bound to every tlal_link instance
`timescale 1ns/1ps
module tlal_link_monitor #(
   parameter [31:0] JAB_CYC = 32'h32,
   parameter [31:0] QUIET_CYC = 32'h14
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic mac_tx_en,
   input wire logic rx_active,
   input wire logic tx_gate,
   input wire logic tx_link_pulse,
   input wire logic flp_send,
   input wire logic collision,
   input wire logic speed_100,
   input wire logic full_duplex
);
   logic [31:0] qcnt;
   logic [31:0] txcnt;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Cycles since reset, held at QUIET_CYC, and length of the current transmit request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         qcnt <= 32'h0;
         txcnt <= 32'h0;
      end else begin
         qcnt <= (qcnt < QUIET_CYC) ? qcnt + 32'h1 : qcnt;
         txcnt <= mac_tx_en ? txcnt + 32'h1 : 32'h0;
      end
   end
   a_coll_mode: assert property (collision |-> !full_duplex && !speed_100)
      else $error("collision outside 10M half duplex");
   a_coll_cause: assert property (collision |-> $past(mac_tx_en) && $past(rx_active))
      else $error("collision without transmit and receive");
   a_pulse_width: assert property ($rose(tx_link_pulse) |->
      tx_link_pulse[*4] ##1 !tx_link_pulse)
      else $error("link pulse not four cycles wide");
   a_pulse_space: assert property ($fell(tx_link_pulse) |-> !tx_link_pulse[*4])
      else $error("link pulses too close");
   a_quiet_silent: assert property (qcnt < QUIET_CYC - 32'h1 |->
      !tx_link_pulse && !flp_send)
      else $error("pulses during quiet period");
   a_negot_nodata: assert property (flp_send |-> !tx_gate)
      else $error("data sent while negotiating");
   a_jabber_block: assert property (txcnt > JAB_CYC + 32'h3 && !speed_100 |->
      !tx_gate)
      else $error("transmit not blocked after jabber");
   a_tx_cause: assert property (tx_gate |-> $past(mac_tx_en))
      else $error("transmit without request");
endmodule // tlal_link_monitor
bind tlal_link tlal_link_monitor #(.JAB_CYC(JAB_CYC), .QUIET_CYC(QUIET_CYC))
   i_mon (.clk(clk), .rst_n(rst_n), .mac_tx_en(mac_tx_en),
   .rx_active(rx_active), .tx_gate(tx_gate), .tx_link_pulse(tx_link_pulse),
   .flp_send(flp_send), .collision(collision), .speed_100(speed_100),
   .full_duplex(full_duplex));

// >>> verification/tlal_link_partner.sv
// Purpose: far-end link partner model
// Assumes: mode 0 silent, 1 link pulses, 2 burst exchange then pulses
// Notes: pulse every 8 cycles, burst lasts up to 32 cycles
`timescale 1ns/1ps
module tlal_link_partner (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] mode,
   output logic rx_nlp,
   output logic rx_flp,
   output logic flp_done
);
   logic [4:0] cnt;
   logic sent;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 5'h00;
         sent <= 1'b0;
         rx_nlp <= 1'b0;
         rx_flp <= 1'b0;
         flp_done <= 1'b0;
      end else begin
         cnt <= cnt + 5'h01;
         sent <= (mode == 2'h2) && (sent || cnt == 5'h1F);
         rx_flp <= (mode == 2'h2) && !sent;
         flp_done <= (mode == 2'h2) && !sent && cnt == 5'h1F;
         rx_nlp <= (mode == 2'h1 || sent) && cnt[2:0] == 3'h0;
      end
   end
endmodule // tlal_link_partner

// >>> verification/tlal_link_tb.sv
// Purpose: register, link, jabber and indicator tests
// Assumes: shortened timers, zero wait state register bus
// Notes: partner model drives rx_nlp and rx_flp; nlp_neg driven directly, rx_idle100 tied low
`timescale 1ns/1ps
module tlal_link_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, rx_nlp, rx_flp, flp_done, tx_gate;
   logic collision, full_duplex, speed_100, link_led_n, speed_led_n, fixed;
   logic cs, act_n;
   logic nlp_neg = 1'b0;
   logic mac_tx_en = 1'b0;
   logic rx_active = 1'b0;
   logic rx_data = 1'b0;
   logic [1:0] pmode = 2'h0;
   logic [5:0] pab = 6'h00;
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   always #12.5 clk = ~clk;
   tlal_link #(.JAB_CYC(32'h32), .UNJAB_CYC(32'h64), .QUIET_CYC(32'h14),
      .NLP_GAP_CYC(32'h0A), .BLINK_CYC(32'h04)) i_dut (.clk(clk),
      .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mac_tx_en(mac_tx_en), .rx_active(rx_active),
      .rx_data(rx_data), .rx_nlp(rx_nlp), .rx_nlp_neg(nlp_neg),
      .rx_flp(rx_flp),
      .rx_idle100(1'b0), .flp_done(flp_done), .partner_ability(pab),
      .tx_gate(tx_gate), .tx_link_pulse(), .flp_send(), .collision(collision),
      .carrier_sense(cs), .rx_data_fixed(fixed), .speed_100(speed_100),
      .full_duplex(full_duplex), .link_led_n(link_led_n), .act_led_n(act_n),
      .speed_led_n(speed_led_n));
   tlal_link_partner i_partner (.clk(clk), .rst_n(rst_n), .mode(pmode),
      .rx_nlp(rx_nlp), .rx_flp(rx_flp), .flp_done(flp_done));
   task end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task chkb(input logic seen, input logic exp);
      chk({31'h0, seen}, {31'h0, exp});
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         end_of_test;
      end
   end
   initial begin
      idle(8);
      rst_n <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h00001001);
      apb(1'b1, 12'h008, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0000002F);
      apb(1'b0, 12'h010, 32'h0);
      chkb(err, 1'b1);
      $display("test registers done");
      pmode <= 2'h1;
      rx_data <= 1'b1;
      idle(80);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd & 32'h1FF, 32'h114);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd & 32'h1000, 32'h0);
      chkb(link_led_n, 1'b0);
      chkb(speed_led_n, 1'b1);
      chkb(fixed, 1'b1);
      chkb(act_n, 1'b1);
      $display("test parallel detect done");
      mac_tx_en <= 1'b1;
      rx_active <= 1'b1;
      idle(4);
      chkb(collision, 1'b1);
      chkb(cs, 1'b1);
      rx_active <= 1'b0;
      idle(36);
      mac_tx_en <= 1'b0;
      idle(2);
      mac_tx_en <= 1'b1;
      idle(40);
      chkb(tx_gate, 1'b1);
      idle(20);
      chkb(tx_gate, 1'b0);
      apb(1'b0, 12'h004, 32'h0);
      chkb(rd[9], 1'b1);
      mac_tx_en <= 1'b0;
      idle(50);
      mac_tx_en <= 1'b1;
      idle(3);
      chkb(tx_gate, 1'b0);
      mac_tx_en <= 1'b0;
      idle(110);
      mac_tx_en <= 1'b1;
      idle(3);
      chkb(tx_gate, 1'b1);
      mac_tx_en <= 1'b0;
      $display("test jabber done");
      pmode <= 2'h0;
      pab <= 6'h0F;
      apb(1'b1, 12'h000, 32'h00001201);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd & 32'hF, 32'h1);
      chkb(speed_led_n, 1'b1);
      idle(25);
      pmode <= 2'h2;
      idle(70);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd & 32'hFF, 32'h84);
      chkb(speed_led_n, 1'b0);
      $display("test negotiation done");
      pmode <= 2'h0;
      apb(1'b1, 12'h000, 32'h00000207);
      idle(30);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd & 32'hF, 32'h8);
      chkb(speed_led_n, 1'b0);
      apb(1'b1, 12'h000, 32'h00000203);
      idle(30);
      chkb(speed_led_n, 1'b1);
      mac_tx_en <= 1'b1;
      rx_active <= 1'b1;
      idle(4);
      chkb(full_duplex, 1'b1);
      chkb(collision, 1'b0);
      rx_active <= 1'b0;
      idle(2);
      chkb(cs, 1'b0);
      nlp_neg <= 1'b1;
      idle(1);
      nlp_neg <= 1'b0;
      idle(2);
      chkb(fixed, 1'b0);
      $display("test forced done");
      end_of_test;
   end
endmodule // tlal_link_tb
